// ---- shared/ismp_pkg.sv ----
// package: register map, field positions and records for the status, mask and pad block
package ismp_pkg;
  localparam logic [7:0]  ADDR_STATUS   = 8'h00;
  localparam logic [7:0]  ADDR_MASK     = 8'h04;
  localparam logic [7:0]  ADDR_PADCFG   = 8'h08;
  localparam logic [7:0]  ADDR_RXHOLD   = 8'h0C;
  localparam logic [7:0]  ADDR_TXHOLD   = 8'h10;
  localparam int          BIT_STOP      = 4;
  localparam int          BIT_START     = 3;
  localparam int          BIT_DIR       = 2;
  localparam int          BIT_RXFULL    = 1;
  localparam int          BIT_TXFULL    = 0;
  localparam int          BIT_OVF       = 6;
  localparam int          BIT_DEL2      = 5;
  localparam int          BIT_DEL1      = 4;
  localparam int          MASK_W        = 10;
  localparam logic [15:0] MASK_RESET    = 16'h0000;
  localparam logic [1:0]  PAD_RESET     = 2'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam int          CLK_NS        = 50;
  localparam int          DELAY_LONG_NS = 300;
  localparam int          DELAY_LEG_NS  = 150;
  localparam int          DELAY_LONG_CY = DELAY_LONG_NS / CLK_NS;
  localparam int          DELAY_LEG_CY  = DELAY_LEG_NS / CLK_NS;

  // events from the bus condition detector and shifters
  typedef struct packed {
    logic       start_det;
    logic       stop_det;
    logic       addr_done;
    logic       addr_rw;
    logic       rx_done;
    logic [7:0] rx_byte;
    logic       tx_done;
  } ismp_bus_ev_t;
endpackage

// ---- rtl/ismp_top.sv ----
// status flags, address mask, sda input delay and axi4-lite register slave
`timescale 1ns/10ps
module ismp_top #(
  parameter int DELAY_LONG = ismp_pkg::DELAY_LONG_CY,
  parameter int DELAY_LEG  = ismp_pkg::DELAY_LEG_CY
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  input  wire logic [7:0]           s_axi_awaddr_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  input  wire logic [7:0]           s_axi_araddr_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  input  wire ismp_pkg::ismp_bus_ev_t ev_i,
  input  wire logic [9:0]           rx_addr_i,
  input  wire logic [9:0]           own_addr_i,
  output logic                      addr_match_o,
  output logic [7:0]                tx_byte_o,
  output logic                      tx_load_o,
  input  wire logic                 sda1_raw_i,
  input  wire logic                 sda2_raw_i,
  output logic                      sda1_dly_o,
  output logic                      sda2_dly_o
);
  localparam int DW = (DELAY_LONG > DELAY_LEG) ? DELAY_LONG : DELAY_LEG;

  logic                 stop_seen;
  logic                 start_seen;
  logic                 dir_read;
  logic                 receive_full_flag;
  logic                 transmit_full_flag;
  logic                 receive_overflow_flag;
  logic [9:0]           address_mask_bits;
  logic                 second_port_sda_delay_select;
  logic                 first_port_sda_delay_select;
  logic [7:0]           rx_hold;
  logic                 aw_held;
  logic                 w_held;
  logic [7:0]           aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic [DW-1:0]        sda1_pipe;
  logic [DW-1:0]        sda2_pipe;

  wire        wr_fire   = aw_held && w_held && !s_axi_bvalid_o;
  wire        rd_fire   = s_axi_arvalid_i && !s_axi_rvalid_o;
  wire        wr_lo     = wr_fire && w_strb[0];
  wire        wr_hi     = wr_fire && w_strb[1];
  wire        wr_status = wr_lo && (aw_addr == ismp_pkg::ADDR_STATUS);
  wire        wr_mask   = wr_fire && (aw_addr == ismp_pkg::ADDR_MASK);
  wire        wr_pad    = wr_lo && (aw_addr == ismp_pkg::ADDR_PADCFG);
  wire        wr_tx     = wr_lo && (aw_addr == ismp_pkg::ADDR_TXHOLD);
  wire        rd_rx     = rd_fire && (s_axi_araddr_i == ismp_pkg::ADDR_RXHOLD);
  wire        wr_known  = (aw_addr == ismp_pkg::ADDR_STATUS) ||
                          (aw_addr == ismp_pkg::ADDR_MASK) ||
                          (aw_addr == ismp_pkg::ADDR_PADCFG) ||
                          (aw_addr == ismp_pkg::ADDR_TXHOLD);
  wire        ovf_clr   = wr_status && !w_data[ismp_pkg::BIT_OVF];
  wire [9:0]  diff_bits = (rx_addr_i ^ own_addr_i) & ~address_mask_bits;

  wire [15:0] status_word = {9'h000, receive_overflow_flag, 1'b0, stop_seen, start_seen,
                             dir_read, receive_full_flag, transmit_full_flag};
  wire [15:0] mask_word   = {6'h00, address_mask_bits};
  wire [15:0] pad_word    = {10'h000, second_port_sda_delay_select,
                             first_port_sda_delay_select, 4'h0};

  // read data mux; unmapped offsets answer with slave error and zero data
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  always_comb begin
    next_rresp = ismp_pkg::RESP_OKAY;
    unique case (s_axi_araddr_i)
      ismp_pkg::ADDR_STATUS: next_rdata = {16'h0000, status_word};
      ismp_pkg::ADDR_MASK:   next_rdata = {16'h0000, mask_word};
      ismp_pkg::ADDR_PADCFG: next_rdata = {16'h0000, pad_word};
      ismp_pkg::ADDR_RXHOLD: next_rdata = {24'h000000, rx_hold};
      ismp_pkg::ADDR_TXHOLD: next_rdata = {24'h000000, tx_byte_o};
      default: begin
        next_rdata = 32'h00000000;
        next_rresp = ismp_pkg::RESP_SLVERR;
      end
    endcase
  end

  assign s_axi_awready_o = !aw_held;
  assign s_axi_wready_o  = !w_held;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign addr_match_o    = (diff_bits == 10'h000);

  // write channels are latched independently, then answered together
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= 8'h00;
      w_data         <= 32'h00000000;
      w_strb         <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= ismp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_known ? ismp_pkg::RESP_OKAY : ismp_pkg::RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // read answer stands until rready is seen
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h00000000;
      s_axi_rresp_o  <= ismp_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= next_rdata;
      s_axi_rresp_o  <= next_rresp;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // bus condition flags; a start in the same cycle as a stop is treated as start
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stop_seen  <= 1'b0;
      start_seen <= 1'b0;
      dir_read   <= 1'b0;
    end else begin
      if (ev_i.start_det) begin
        start_seen <= 1'b1;
        stop_seen  <= 1'b0;
      end else if (ev_i.stop_det) begin
        stop_seen  <= 1'b1;
        start_seen <= 1'b0;
      end
      if (ev_i.addr_done) begin
        dir_read <= ev_i.addr_rw;
      end
    end
  end

  // receive holding; a byte arriving while full is dropped and flags overflow
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      receive_full_flag     <= 1'b0;
      receive_overflow_flag <= 1'b0;
      rx_hold               <= 8'h00;
    end else begin
      if (ev_i.rx_done && !receive_full_flag) begin
        rx_hold           <= ev_i.rx_byte;
        receive_full_flag <= 1'b1;
      end else if (rd_rx) begin
        receive_full_flag <= 1'b0;
      end
      if (ev_i.rx_done && receive_full_flag) begin
        receive_overflow_flag <= 1'b1;
      end else if (ovf_clr) begin
        receive_overflow_flag <= 1'b0;
      end
    end
  end

  // transmit holding; a write wins over a same-cycle completion, which clears full only when not writing
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      transmit_full_flag <= 1'b0;
      tx_byte_o          <= 8'h00;
      tx_load_o          <= 1'b0;
    end else begin
      tx_load_o <= wr_tx;
      if (wr_tx) begin
        tx_byte_o          <= w_data[7:0];
        transmit_full_flag <= 1'b1;
      end else if (ev_i.tx_done) begin
        transmit_full_flag <= 1'b0;
      end
    end
  end

  // software-writable mask and delay selects
  // upper mask bits and unused pad bits are not stored, so they read zero
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      address_mask_bits            <= ismp_pkg::MASK_RESET[9:0];
      second_port_sda_delay_select <= ismp_pkg::PAD_RESET[1];
      first_port_sda_delay_select  <= ismp_pkg::PAD_RESET[0];
    end else begin
      if (wr_mask && w_strb[0]) begin
        address_mask_bits[7:0] <= w_data[7:0];
      end
      if (wr_mask && wr_hi) begin
        address_mask_bits[9:8] <= w_data[9:8];
      end
      if (wr_pad) begin
        second_port_sda_delay_select <= w_data[ismp_pkg::BIT_DEL2];
        first_port_sda_delay_select  <= w_data[ismp_pkg::BIT_DEL1];
      end
    end
  end

  // sda input delay lines, tap chosen per port
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sda1_pipe <= '1;
      sda2_pipe <= '1;
    end else begin
      sda1_pipe <= {sda1_pipe[DW-2:0], sda1_raw_i};
      sda2_pipe <= {sda2_pipe[DW-2:0], sda2_raw_i};
    end
  end
  assign sda1_dly_o = first_port_sda_delay_select ? sda1_pipe[DELAY_LONG-1]
                                                  : sda1_pipe[DELAY_LEG-1];
  assign sda2_dly_o = second_port_sda_delay_select ? sda2_pipe[DELAY_LONG-1]
                                                   : sda2_pipe[DELAY_LEG-1];

  // event steps: a condition pulse, then the flag; a byte, then the holding state
  sequence s_stop_alone;
    ev_i.stop_det && !ev_i.start_det;
  endsequence

  sequence s_start_any;
    ev_i.start_det;
  endsequence

  sequence s_rx_fill;
    ev_i.rx_done && !receive_full_flag;
  endsequence

  sequence s_rx_spill;
    ev_i.rx_done && receive_full_flag;
  endsequence

  sequence s_tx_write;
    wr_tx;
  endsequence

  sequence s_tx_drain;
    ev_i.tx_done && !wr_tx;
  endsequence

  a_stop_flag: assert property (@(posedge clock_i) disable iff (rst_i)
    s_stop_alone |=> stop_seen && !start_seen)
    else $error("stop did not set stop flag");

  a_start_flag: assert property (@(posedge clock_i) disable iff (rst_i)
    s_start_any |=> start_seen && !stop_seen)
    else $error("start did not set start flag");

  a_dir_update: assert property (@(posedge clock_i) disable iff (rst_i)
    ev_i.addr_done |=> dir_read == $past(ev_i.addr_rw))
    else $error("direction flag not updated");

  a_rx_full: assert property (@(posedge clock_i) disable iff (rst_i)
    s_rx_fill |=> receive_full_flag && rx_hold == $past(ev_i.rx_byte))
    else $error("receive holding not filled");

  a_rx_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_rx && !ev_i.rx_done |=> !receive_full_flag)
    else $error("receive full not cleared by read");

  a_tx_full: assert property (@(posedge clock_i) disable iff (rst_i)
    s_tx_write |=> transmit_full_flag && tx_load_o)
    else $error("transmit full not set");

  a_tx_done: assert property (@(posedge clock_i) disable iff (rst_i)
    s_tx_drain |=> !transmit_full_flag)
    else $error("transmit full not cleared");

  a_tx_load_once: assert property (@(posedge clock_i) disable iff (rst_i)
    tx_load_o |-> $past(wr_tx))
    else $error("transmit load pulse without a write");

  a_mask_match: assert property (@(posedge clock_i) disable iff (rst_i)
    address_mask_bits == 10'h3FF |-> addr_match_o)
    else $error("full mask must always match");

  a_mask_exact: assert property (@(posedge clock_i) disable iff (rst_i)
    address_mask_bits == 10'h000 |-> addr_match_o == (rx_addr_i == own_addr_i))
    else $error("clear mask must need an exact match");

  a_mask_upper: assert property (@(posedge clock_i) disable iff (rst_i)
    mask_word[15:10] == 6'h00)
    else $error("upper mask bits not zero");

  a_pad_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    pad_word[15:6] == 10'h000 && pad_word[3:0] == 4'h0)
    else $error("unimplemented pad bits not zero");

  a_ovf_set: assert property (@(posedge clock_i) disable iff (rst_i)
    s_rx_spill |=> receive_overflow_flag && $stable(rx_hold))
    else $error("overflow not flagged");

  a_ovf_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    ovf_clr && !(ev_i.rx_done && receive_full_flag) |=> !receive_overflow_flag)
    else $error("overflow not cleared by software");

  a_delay_second: assert property (@(posedge clock_i) disable iff (rst_i)
    second_port_sda_delay_select |-> sda2_dly_o == $past(sda2_raw_i, DELAY_LONG))
    else $error("second port long delay wrong");

  a_legacy_second: assert property (@(posedge clock_i) disable iff (rst_i)
    !second_port_sda_delay_select |-> sda2_dly_o == $past(sda2_raw_i, DELAY_LEG))
    else $error("second port legacy delay wrong");

  a_delay_first: assert property (@(posedge clock_i) disable iff (rst_i)
    first_port_sda_delay_select |-> sda1_dly_o == $past(sda1_raw_i, DELAY_LONG))
    else $error("first port long delay wrong");

  a_legacy_first: assert property (@(posedge clock_i) disable iff (rst_i)
    !first_port_sda_delay_select |-> sda1_dly_o == $past(sda1_raw_i, DELAY_LEG))
    else $error("first port legacy delay wrong");

  a_reset_clean: assert property (@(posedge clock_i) disable iff (rst_i)
    $past(rst_i) |-> address_mask_bits == 10'h000 && !first_port_sda_delay_select
                     && !second_port_sda_delay_select)
    else $error("mask or pad select not zero after reset");

  a_bvalid_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped early");

  a_rvalid_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read response dropped early");
endmodule // ismp_top

// ---- testbench/ismp_bus_partner.sv ----
// far-side bus model: condition, address, byte and sda events
`timescale 1ns/10ps
module ismp_bus_partner (
  input  wire logic             clock_i,
  output ismp_pkg::ismp_bus_ev_t ev_o,
  output logic                  sda1_o,
  output logic                  sda2_o
);
  // released sda lines sit at the pull-up level
  initial begin
    ev_o = '0;
    sda1_o = 1'b1;
    sda2_o = 1'b1;
  end
  task automatic pulse(input ismp_pkg::ismp_bus_ev_t e);
    @(posedge clock_i);
    ev_o <= e;
    @(posedge clock_i);
    ev_o <= '0;
  endtask
  task automatic cond(input logic s, input logic p);
    ismp_pkg::ismp_bus_ev_t e;
    e = '0;
    e.start_det = s;
    e.stop_det = p;
    pulse(e);
  endtask
  task automatic addr(input logic rw);
    ismp_pkg::ismp_bus_ev_t e;
    e = '0;
    e.addr_done = 1'b1;
    e.addr_rw = rw;
    pulse(e);
  endtask
  task automatic rx(input logic [7:0] b);
    ismp_pkg::ismp_bus_ev_t e;
    e = '0;
    e.rx_done = 1'b1;
    e.rx_byte = b;
    pulse(e);
  endtask
  task automatic txd();
    ismp_pkg::ismp_bus_ev_t e;
    e = '0;
    e.tx_done = 1'b1;
    pulse(e);
  endtask
  task automatic sda(input logic a, input logic b);
    @(posedge clock_i);
    sda1_o <= a;
    sda2_o <= b;
  endtask
endmodule // ismp_bus_partner

// ---- testbench/ismp_tb_top.sv ----
// self-checking bench for the status, mask and pad block
`timescale 1ns/10ps
module ismp_tb_top;
  localparam int LONG = 6;
  localparam int LEG  = 3;
  logic clock_i = 0, rst_i = 1;
  logic [7:0] awaddr = 0, araddr = 0, tx_byte;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, match, tx_load, s1, s2, d1, d2;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp;
  logic [9:0] rxa = 0, owna = 0;
  ismp_pkg::ismp_bus_ev_t ev;
  int num_errors = 0, compares = 0, cyc = 0, es = 0;
  ismp_top #(.DELAY_LONG(LONG), .DELAY_LEG(LEG)) ismp_top_i (.clock_i(clock_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ev_i(ev), .rx_addr_i(rxa),
    .own_addr_i(owna), .addr_match_o(match), .tx_byte_o(tx_byte), .tx_load_o(tx_load),
    .sda1_raw_i(s1), .sda2_raw_i(s2), .sda1_dly_o(d1), .sda2_dly_o(d2));
  ismp_bus_partner ismp_bus_partner_i (.clock_i(clock_i), .ev_o(ev), .sda1_o(s1), .sda2_o(s2));
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clock_i);
    awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1; bready <= 1;
    while (!bvalid) begin
      @(posedge clock_i);
      if (awvalid && awready && !ad) begin ad = 1; awvalid <= 0; end
      if (wvalid && wready && !wd) begin wd = 1; wvalid <= 0; end
    end
    bready <= 0;
    chk("bresp", ismp_pkg::RESP_OKAY, bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clock_i);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge clock_i); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge clock_i);
    rready <= 0;
    chk("rresp", er, rresp);
    chk("rdata", e, rdata);
  endtask
  task automatic rs(input logic [7:0] a, input int e);
    rd(a, e, ismp_pkg::RESP_OKAY);
  endtask
  initial begin
    int m, n1, n2;
    repeat (12) @(posedge clock_i);
    rst_i <= 0;
    void'($urandom(3030));
    rs(ismp_pkg::ADDR_MASK, 0);
    rs(ismp_pkg::ADDR_PADCFG, 0);
    rs(ismp_pkg::ADDR_STATUS, 0);
    rd(8'h14, 0, ismp_pkg::RESP_SLVERR);
    wr(ismp_pkg::ADDR_MASK, 32'hFFFF_FFFF);
    rs(ismp_pkg::ADDR_MASK, 32'h3FF);
    ismp_bus_partner_i.cond(1, 0);
    es = 32'h08;
    rs(ismp_pkg::ADDR_STATUS, es);
    ismp_bus_partner_i.cond(0, 1);
    es = 32'h10;
    rs(ismp_pkg::ADDR_STATUS, es);
    ismp_bus_partner_i.cond(1, 1);
    es = 32'h08;
    rs(ismp_pkg::ADDR_STATUS, es);
    ismp_bus_partner_i.addr(1);
    rs(ismp_pkg::ADDR_STATUS, es | 4);
    ismp_bus_partner_i.addr(0);
    rs(ismp_pkg::ADDR_STATUS, es);
    m = $urandom & 8'hFF;
    ismp_bus_partner_i.rx(m[7:0]);
    rs(ismp_pkg::ADDR_STATUS, es | 2);
    ismp_bus_partner_i.rx(~m[7:0]);
    rs(ismp_pkg::ADDR_STATUS, es | 32'h42);
    rs(ismp_pkg::ADDR_RXHOLD, m);
    rs(ismp_pkg::ADDR_STATUS, es | 32'h40);
    wr(ismp_pkg::ADDR_STATUS, 0);
    rs(ismp_pkg::ADDR_STATUS, es);
    wr(ismp_pkg::ADDR_TXHOLD, 32'h5A);
    chk("tx_byte", 32'h5A, tx_byte);
    chk("tx_load", 1, tx_load);
    rs(ismp_pkg::ADDR_STATUS, es | 1);
    ismp_bus_partner_i.txd();
    rs(ismp_pkg::ADDR_STATUS, es);
    for (int i = 0; i < 24; i++) begin
      m = $urandom & 32'h3FF;
      wr(ismp_pkg::ADDR_MASK, m);
      @(posedge clock_i);
      n1 = $urandom & 32'h3FF;
      n2 = (i % 2) ? ($urandom & 32'h3FF) : (n1 ^ ($urandom & m));
      rxa <= n1[9:0];
      owna <= n2[9:0];
      @(negedge clock_i);
      chk("match", 32'(((n1 ^ n2) & ~m & 32'h3FF) == 0), 32'(match));
    end
    for (int p = 0; p < 4; p++) begin
      wr(ismp_pkg::ADDR_PADCFG, 32'hFFCF | (p << 4));
      rs(ismp_pkg::ADDR_PADCFG, p << 4);
      ismp_bus_partner_i.sda(1, 1);
      repeat (8) @(posedge clock_i);
      ismp_bus_partner_i.sda(0, 0);
      n1 = 0;
      n2 = 0;
      for (int c = 1; c <= 10; c++) begin
        @(posedge clock_i);
        #1;
        if (d1 === 1'b0 && n1 == 0) n1 = c;
        if (d2 === 1'b0 && n2 == 0) n2 = c;
      end
      chk("sda1 delay", p[0] ? LONG : LEG, n1);
      chk("sda2 delay", p[1] ? LONG : LEG, n2);
    end
    close_out();
  end
endmodule // ismp_tb_top
